// File: rtl/see_defs.vh
// Purpose: Shared constants for the serial EEPROM access block.
// Assumes: Plain Verilog-2005 includer.
// Notes:   Timing counts derive from the 100 MHz system clock.
`ifndef SEE_DEFS_VH
`define SEE_DEFS_VH
`define SEE_ADDR_W       8
`define SEE_PAGE_W       4
`define SEE_DEV_CODE     4'ha
`define SEE_CLK_MHZ      100
`define SEE_TWR_US       5000
`define SEE_TWR_CYC      (`SEE_TWR_US * `SEE_CLK_MHZ)
`define SEE_BIT_LAST     4'h7
`define SEE_BIT_ACK      4'h8
`define SEE_MEM_INIT     8'hff
`endif

// File: rtl/see_mem.v
// Purpose: Byte array with registered read data.
// Assumes: One write port and one read port on mclk.
// Notes:   Contents are not reset.
`timescale 1ns/1ps
`default_nettype none
module see_mem #(
	parameter AW = 8
) (
	input  wire          mclk,
	input  wire          wrEn,
	input  wire [AW-1:0] wrAddr,
	input  wire [7:0]    wrData,
	input  wire [AW-1:0] rdAddr,
	output reg  [7:0]    rdData
);
	reg [7:0] mem [0:(1<<AW)-1];
	always @(posedge mclk) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
		rdData <= mem[rdAddr];
	end
endmodule
`default_nettype wire

// File: rtl/see_i2c_eeprom.v
// Purpose: Slave-side access logic of a 2-kbit two-wire serial EEPROM.
// Assumes: SCL and SDA are sampled by mclk; the master makes SCL.
// Notes:   The programming cycle is a timed busy period; the array is ideal.
`timescale 1ns/1ps
`default_nettype none
`include "see_defs.vh"
// How it works
// - Write-addressed frame loads 8-bit word pointer.
// - Stop after data starts programming cycle.
// - Busy programming ignores and never acknowledges.
// - Each write byte acked, page bits advance.
// - Over sixteen bytes wrap within page.
// - Only loaded page bytes programmed in one cycle.
// - Address not acked while busy, acked after.
// - Protect input: ack addresses, nack data, no programming.
// - Direction bit one selects read transfer.
// - Counter holds one past last access.
// - Counter wraps from 255 to zero.
// - Current read: ack address, send one byte.
// - Random read via dummy write, repeated start.
// - Master ack requests next sequential byte.
// - Reads increment all address bits.
// - Missing master ack ends sending until stop.
// - Supervisor reset aborts transfers, not programming; blocks new writes.
module see_i2c_eeprom #(
	parameter        AW      = `SEE_ADDR_W,
	parameter        PW      = `SEE_PAGE_W,
	parameter [3:0]  DEVCODE = `SEE_DEV_CODE,
	parameter [31:0] TWR_CYC = `SEE_TWR_CYC
) (
	input  wire mclk,
	input  wire reset_n,
	input  wire scl,
	input  wire sdaIn,
	input  wire writeProtect,
	input  wire supReset,
	output reg  sdaOut,
	output reg  sdaOe,
	output reg  busy
);
	localparam [2:0] ST_IDLE = 3'h0, ST_DEV = 3'h1, ST_WORD = 3'h2, ST_WDAT = 3'h3,
		ST_RDAT = 3'h4, ST_RACK = 3'h5, ST_PROG = 3'h6;
	localparam NPG = 1 << PW;
	// ----------------------------------------
	// Input synchronisers.
	// ----------------------------------------
	reg [1:0] sclSync_q, sdaSync_q, wpSync_q, supSync_q;
	reg       sclPrev_q, sdaPrev_q;
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			sclSync_q <= 2'h3;
			sdaSync_q <= 2'h3;
			wpSync_q  <= 2'h0;
			supSync_q <= 2'h0;
			sclPrev_q <= 1'b1;
			sdaPrev_q <= 1'b1;
		end else begin
			sclSync_q <= {sclSync_q[0], scl};
			sdaSync_q <= {sdaSync_q[0], sdaIn};
			wpSync_q  <= {wpSync_q[0], writeProtect};
			supSync_q <= {supSync_q[0], supReset};
			sclPrev_q <= sclSync_q[1];
			sdaPrev_q <= sdaSync_q[1];
		end
	end
	wire sclC    = sclSync_q[1];
	wire sdaC    = sdaSync_q[1];
	wire sclRise = sclC & ~sclPrev_q;
	wire sclFall = ~sclC & sclPrev_q;
	wire startC  = sclC & sclPrev_q & sdaPrev_q & ~sdaC;
	wire stopC   = sclC & sclPrev_q & ~sdaPrev_q & sdaC;
	wire wpC     = wpSync_q[1];
	wire supC    = supSync_q[1];
	// ----------------------------------------
	// Protocol state.
	// ----------------------------------------
	reg [2:0]    state_q;
	reg [3:0]    bitCnt_q;
	reg [7:0]    shift_q;
	reg          ackPh_q;
	reg          ackDrv_q;
	reg [AW-1:0] addr_q;
	reg [AW-1:0] pgBase_q;
	reg [NPG-1:0] pgVal_q;
	reg [7:0]    pgBuf_q [0:NPG-1];
	reg          wrote_q;
	reg          wpHit_q;
	reg [31:0]   twr_q;
	reg [PW:0]   progIdx_q;
	wire [7:0]   memRd;
	wire         memWe = (state_q == ST_PROG) && (progIdx_q < NPG) && pgVal_q[progIdx_q[PW-1:0]];
	wire [AW-1:0] memWa = {pgBase_q[AW-1:PW], progIdx_q[PW-1:0]};
	see_mem #(.AW(AW)) u_see_mem (
		.mclk   (mclk),
		.wrEn   (memWe),
		.wrAddr (memWa),
		.wrData (pgBuf_q[progIdx_q[PW-1:0]]),
		.rdAddr (addr_q),
		.rdData (memRd)
	);
	wire [7:0] rxByte = {shift_q[6:0], sdaC};
	wire       devHit = (rxByte[7:4] == DEVCODE);
	integer i;
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			state_q   <= ST_IDLE;
			bitCnt_q  <= 4'h0;
			shift_q   <= 8'h00;
			ackPh_q   <= 1'b0;
			ackDrv_q  <= 1'b0;
			addr_q    <= {AW{1'b0}};
			pgBase_q  <= {AW{1'b0}};
			pgVal_q   <= {NPG{1'b0}};
			wrote_q   <= 1'b0;
			wpHit_q   <= 1'b0;
			twr_q     <= 32'h0;
			progIdx_q <= {(PW+1){1'b0}};
			sdaOut    <= 1'b0;
			sdaOe     <= 1'b0;
			busy      <= 1'b0;
			for (i = 0; i < NPG; i = i + 1) begin
				pgBuf_q[i] <= `SEE_MEM_INIT;
			end
		end else begin
			sdaOut <= 1'b0;
			if (state_q == ST_PROG) begin
				busy  <= 1'b1;
				sdaOe <= 1'b0;
				if (progIdx_q < NPG) begin
					progIdx_q <= progIdx_q + 1'b1;
				end
				if (twr_q >= TWR_CYC - 1) begin
					state_q <= ST_IDLE;
					busy    <= 1'b0;
					pgVal_q <= {NPG{1'b0}};
				end else begin
					twr_q <= twr_q + 32'h1;
				end
			end else if (supC) begin
				state_q <= ST_IDLE;
				sdaOe   <= 1'b0;
				pgVal_q <= {NPG{1'b0}};
				wrote_q <= 1'b0;
			end else if (stopC) begin
				sdaOe <= 1'b0;
				if (wrote_q && !wpHit_q) begin
					state_q   <= ST_PROG;
					busy      <= 1'b1;
					twr_q     <= 32'h0;
					progIdx_q <= {(PW+1){1'b0}};
				end else begin
					state_q <= ST_IDLE;
				end
				wrote_q <= 1'b0;
			end else if (startC) begin
				state_q  <= ST_DEV;
				bitCnt_q <= 4'h0;
				ackPh_q  <= 1'b0;
				sdaOe    <= 1'b0;
				wrote_q  <= 1'b0;
				wpHit_q  <= 1'b0;
				pgVal_q  <= {NPG{1'b0}};
			end else if (state_q == ST_IDLE) begin
				sdaOe <= 1'b0;
			end else if (sclFall) begin
				if (ackPh_q) begin
					ackPh_q  <= 1'b0;
					bitCnt_q <= 4'h0;
					if (state_q == ST_RDAT) begin
						sdaOe <= ~memRd[7];
						shift_q <= memRd;
						addr_q <= addr_q + 1'b1;
					end else begin
						sdaOe <= 1'b0;
					end
				end else if (bitCnt_q == `SEE_BIT_ACK) begin
					ackPh_q <= 1'b1;
					sdaOe   <= ackDrv_q;
				end else if (state_q == ST_RDAT) begin
					sdaOe <= ~shift_q[7];
				end else begin
					sdaOe <= 1'b0;
				end
			end else if (sclRise) begin
				if (ackPh_q) begin
					if (state_q == ST_RACK) begin
						if (sdaC) begin
							state_q <= ST_IDLE;
						end else begin
							state_q <= ST_RDAT;
							ackPh_q <= 1'b1;
						end
					end
				end else if (state_q == ST_RDAT && bitCnt_q != `SEE_BIT_ACK) begin
					shift_q  <= {shift_q[6:0], 1'b1};
					bitCnt_q <= bitCnt_q + 4'h1;
					if (bitCnt_q == `SEE_BIT_LAST) begin
						state_q  <= ST_RACK;
						bitCnt_q <= `SEE_BIT_ACK;
						ackDrv_q <= 1'b0;
					end
				end else if (bitCnt_q != `SEE_BIT_ACK) begin
					shift_q  <= rxByte;
					bitCnt_q <= bitCnt_q + 4'h1;
					if (bitCnt_q == `SEE_BIT_LAST) begin
						ackDrv_q <= 1'b0;
						case (state_q)
						ST_DEV: begin
							if (!devHit) begin
								state_q <= ST_IDLE;
							end else if (rxByte[0]) begin
								ackDrv_q <= 1'b1;
								state_q  <= ST_RDAT;
							end else begin
								ackDrv_q <= 1'b1;
								state_q  <= ST_WORD;
							end
						end
						ST_WORD: begin
							addr_q   <= rxByte;
							pgBase_q <= rxByte;
							ackDrv_q <= 1'b1;
							state_q  <= ST_WDAT;
						end
						ST_WDAT: begin
							if (wpC) begin
								wpHit_q <= 1'b1;
							end else begin
								ackDrv_q <= 1'b1;
								wrote_q  <= 1'b1;
								pgBuf_q[addr_q[PW-1:0]] <= rxByte;
								pgVal_q[addr_q[PW-1:0]] <= 1'b1;
								addr_q <= {addr_q[AW-1:PW], addr_q[PW-1:0] + 1'b1};
							end
						end
						default: begin
							state_q <= ST_IDLE;
						end
						endcase
					end
				end else begin
					bitCnt_q <= bitCnt_q;
				end
			end
		end
	end
	// Read byte count of 8 plus ack: first read byte loads on the ack fall of the address.
endmodule
`default_nettype wire

// File: testbench/see_i2c_eeprom_checker.sv
// Purpose: Pin assertions for the EEPROM slave.
// Assumes: Bound to see_i2c_eeprom.
// Notes:   Busy length follows TWR_CYC.
`timescale 1ns/1ps
`default_nettype none
module see_chk #(
	parameter [31:0] TWR_CYC = 200
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic scl,
	input wire logic sdaIn,
	input wire logic writeProtect,
	input wire logic supReset,
	input wire logic sdaOut,
	input wire logic sdaOe,
	input wire logic busy
);
	logic [31:0] cnt_q;
	always_ff @(posedge mclk or negedge reset_n)
		if (!reset_n) cnt_q <= '0;
		else cnt_q <= busy ? cnt_q + 1 : '0;
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	a_busy_mute: assert property (busy |-> !sdaOe) else $error("ack while busy");
	a_busy_stop: assert property ($rose(busy) |-> (scl && sdaIn)) else $error("no stop");
	a_busy_long: assert property (cnt_q <= TWR_CYC + 4) else $error("busy long");
	a_busy_full: assert property ($fell(busy) |-> cnt_q + 4 >= TWR_CYC) else $error("short");
	a_prot_hold: assert property ($rose(busy) |-> !writeProtect) else $error("wp write");
	a_sup_start: assert property (supReset && $past(supReset, 4) && !busy |=> !busy)
		else $error("write in reset");
	a_sup_mute: assert property (supReset && $past(supReset, 4) |-> !sdaOe) else $error("ack");
	a_sda_steady: assert property ($changed(sdaOe) |-> !scl) else $error("sda moved");
endmodule
bind see_i2c_eeprom see_chk #(.TWR_CYC(TWR_CYC)) u_see_chk (.mclk, .reset_n, .scl, .sdaIn,
	.writeProtect, .supReset, .sdaOut, .sdaOe, .busy);
`default_nettype wire

// File: testbench/see_mst.sv
// Purpose: Two-wire bus master model with pull-up on SDA.
// Assumes: SCL period 80 ns, idle high between frames.
// Notes:   Changes come 1 ns after an mclk edge.
`timescale 1ns/1ps
`default_nettype none
module see_mst (
	input wire logic  mclk,
	input wire logic  sdaOe,
	output logic      scl,
	output wire logic sdaIn
);
	logic sdaDrv = 1'b1;
	initial scl = 1'b1;
	assign sdaIn = sdaOe ? 1'b0 : sdaDrv;
	task q(input int n);
		repeat (2 * n) @(posedge mclk);
		#1;
	endtask
	task start;
		sdaDrv = 1'b1;
		q(1);
		scl = 1'b1;
		q(2);
		sdaDrv = 1'b0;
		q(2);
		scl = 1'b0;
		q(1);
	endtask
	task stop;
		sdaDrv = 1'b0;
		q(1);
		scl = 1'b1;
		q(2);
		sdaDrv = 1'b1;
		q(2);
	endtask
	task xfer(input logic [8:0] tx, output logic [8:0] rx);
		for (int i = 8; i >= 0; i--) begin
			sdaDrv = tx[i];
			q(1);
			scl = 1'b1;
			q(2);
			rx[i] = sdaIn;
			scl = 1'b0;
			q(1);
		end
	endtask
endmodule
`default_nettype wire

// File: testbench/test_see_i2c_eeprom.sv
// Purpose: Self-checking bench for the EEPROM slave.
// Assumes: Short programming cycle of 200 mclk.
// Notes:   Master model drives the bus.
`timescale 1ns/1ps
`default_nettype none
module test_see_i2c_eeprom;
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic writeProtect = 1'b0;
	logic supReset = 1'b0;
	wire scl, sdaIn, sdaOut, sdaOe, busy;
	int err_count = 0;
	int checks_done = 0;
	logic [8:0] rx;
	always #5 mclk = ~mclk;
	see_i2c_eeprom #(.TWR_CYC(200)) u_see_i2c_eeprom (.mclk, .reset_n, .scl, .sdaIn,
		.writeProtect, .supReset, .sdaOut, .sdaOe, .busy);
	see_mst u_see_mst (.mclk, .sdaOe, .scl, .sdaIn);
	task chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task final_report;
		$display("checks=%0d errors=%0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task wb(input logic [7:0] b, input logic nack);
		u_see_mst.xfer({b, 1'b1}, rx);
		chk({7'h0, rx[0]}, {7'h0, nack});
	endtask
	task rb(input logic more, input logic [7:0] exp);
		u_see_mst.xfer({8'hff, !more}, rx);
		chk(rx[8:1], exp);
	endtask
	task poll;
		int n;
		n = 0;
		do begin
			u_see_mst.start;
			u_see_mst.xfer(9'h141, rx);
			u_see_mst.stop;
			n++;
		end while (rx[0] && n < 20);
		chk({7'h0, rx[0]}, 8'h0);
	endtask
	task wr(input logic [7:0] a, input int n, input logic [7:0] d0, input logic doPoll);
		u_see_mst.start;
		wb(8'ha0, 1'b0);
		wb(a, 1'b0);
		for (int i = 0; i < n; i++) wb(d0 + 8'(i), 1'b0);
		u_see_mst.stop;
		chk({7'h0, busy}, 8'h1);
		u_see_mst.start;
		wb(8'ha0, 1'b1);
		u_see_mst.stop;
		if (doPoll) poll;
		$display("write %h done", a);
	endtask
	task seek(input logic [7:0] a);
		u_see_mst.start;
		wb(8'ha0, 1'b0);
		wb(a, 1'b0);
		u_see_mst.start;
		wb(8'ha1, 1'b0);
	endtask
	task t_read;
		u_see_mst.start;
		wb(8'hb0, 1'b1);
		u_see_mst.stop;
		seek(8'hfe);
		rb(1'b1, 8'h20);
		rb(1'b1, 8'h21);
		rb(1'b0, 8'h5a);
		u_see_mst.stop;
		u_see_mst.start;
		wb(8'ha1, 1'b0);
		rb(1'b0, 8'h5b);
		u_see_mst.stop;
		$display("read done");
	endtask
	task t_prot;
		writeProtect = 1'b1;
		u_see_mst.start;
		wb(8'ha0, 1'b0);
		wb(8'h00, 1'b0);
		wb(8'hc3, 1'b1);
		u_see_mst.stop;
		u_see_mst.q(10);
		chk({7'h0, busy}, 8'h0);
		chk({7'h0, sdaOut}, 8'h0);
		writeProtect = 1'b0;
		seek(8'h00);
		rb(1'b0, 8'h5a);
		u_see_mst.stop;
		$display("protect done");
	endtask
	task t_sup;
		wr(8'h01, 1, 8'h33, 1'b0);
		supReset = 1'b1;
		u_see_mst.q(100);
		u_see_mst.start;
		wb(8'ha0, 1'b1);
		u_see_mst.stop;
		supReset = 1'b0;
		poll;
		seek(8'h00);
		rb(1'b1, 8'h5a);
		rb(1'b0, 8'h33);
		u_see_mst.stop;
		$display("supervisor done");
	endtask
	initial begin
		repeat (16) @(posedge mclk);
		#1 reset_n = 1'b1;
		u_see_mst.q(2);
		wr(8'hfe, 18, 8'h10, 1'b1);
		wr(8'h00, 2, 8'h5a, 1'b1);
		t_read;
		t_prot;
		t_sup;
		final_report;
	end
	initial begin
		#500us;
		err_count++;
		final_report;
	end
endmodule
`default_nettype wire
